// ==== bench/display_mode_command_handler_tb.sv ====
`timescale 1ns/10ps
module display_mode_command_handler_tb
  import dmc_pkg::*;
;
  logic        clk_i, rst_n_i, soft_rst_i;
  logic        cmd_valid, cmd_wide;
  logic [15:0] cmd_code;
  logic        asleep, partial, inverted, upd, hwait, terr;
  int          err_count, total_checks, seed, k, g;
  int          m_sleep, m_part, m_inv, m_err, m_upd, m_wait, m_out;
  logic [7:0]  ops [7];

  dmc_host_model u_host (.cmd_valid_o(cmd_valid), .cmd_wide_o(cmd_wide),
                         .cmd_code_o(cmd_code));
  dmc_mode_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .soft_rst_i(soft_rst_i), .cmd_valid_i(cmd_valid),
    .cmd_wide_i(cmd_wide), .cmd_code_i(cmd_code), .asleep_o(asleep),
    .partial_o(partial), .inverted_o(inverted), .mode_update_o(upd),
    .host_wait_o(hwait), .timing_err_o(terr));

  // Clock at 25 MHz.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Ends the run with the verdict.
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Compares one output with the model.
  task automatic chk(input string nm, input logic got, input int exp);
    total_checks++;
    if (got !== exp[0]) begin
      err_count++;
      $display("Error %s expected %0d seen %b", nm, exp, got);
    end
  endtask : chk

  // Model state after a reset; a full reset also stops the wait counters.
  task automatic mreset(input bit full);
    m_sleep = 1;
    m_part  = 0;
    m_inv   = 0;
    m_err   = 0;
    if (full) m_upd = 0;
    if (full) m_wait = 0;
    if (full) m_out = 0;
  endtask : mreset

  // Checks last cycle's result, then drives one cycle and steps the model.
  task automatic step(input logic s, input logic v, input logic w,
                      input logic [7:0] op, input logic [7:0] lo);
    @(negedge clk_i);
    chk("partial_o", partial, m_part);
    chk("asleep_o", asleep, m_sleep);
    chk("inverted_o", inverted, m_inv);
    chk("mode_update_o", upd, m_upd);
    chk("host_wait_o", hwait, m_wait);
    chk("timing_err_o", terr, m_err);
    soft_rst_i = s;
    u_host.drive(v, w, op, lo);
    m_upd = 0;
    if (s) begin
      m_upd = m_part;
      mreset(0);
    end
    if (v && m_wait) m_err = 1;
    if (v && (!w || lo == 8'h00) && op == DMC_SER_SLEEP_ENTRY && m_out)
      m_err = 1;
    if (!s && v && (!w || lo == 8'h00)) begin
      case (op)
        DMC_SER_SLEEP_ENTRY: begin
          if (!m_sleep) m_wait = 1;
          m_sleep = 1;
        end
        DMC_SER_SLEEP_EXIT: begin
          if (m_sleep) m_out = 1;
          m_sleep = 0;
        end
        DMC_SER_PARTIAL: begin
          m_upd  = !m_part;
          m_part = 1;
        end
        DMC_SER_NORMAL: begin
          m_upd  = m_part;
          m_part = 0;
        end
        DMC_SER_INV_CLEAR: m_inv = 0;
        DMC_SER_INV_SET: m_inv = 1;
        default: ;
      endcase
    end
  endtask : step

  // Watchdog well beyond the expected run length.
  initial begin
    #(40 * 5000);
    err_count++;
    final_report();
  end

  // Main sequence.
  initial begin
    rst_n_i    = 1'b0;
    soft_rst_i = 1'b0;
    seed       = 32'h6ba9046d;
    ops = '{DMC_SER_SLEEP_EXIT, DMC_SER_PARTIAL, DMC_SER_NORMAL,
            DMC_SER_INV_CLEAR, DMC_SER_INV_SET, 8'h55, DMC_SER_NORMAL};
    mreset(1);
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    // Random traffic, asleep first; no sleep entry so host waits hold.
    for (int i = 0; i < 300; i++) begin
      k = $unsigned($random(seed)) % 7;
      step(0, 1, 1'($random(seed)), ops[k],
           (($random(seed) & 7) == 0) ? 8'h01 : 8'h00);
      g = $unsigned($random(seed)) % 3;
      repeat (g) step(0, 0, 0, 8'h00, 8'h00);
    end
    step(0, 1, 1, DMC_SER_NORMAL, 8'h00);
    step(0, 1, 1, DMC_SER_PARTIAL, 8'h00);
    step(1, 1, 0, DMC_SER_PARTIAL, 8'h00);
    step(0, 1, 1, DMC_SER_SLEEP_EXIT, 8'h00);
    step(0, 1, 0, DMC_SER_SLEEP_ENTRY, 8'h00);
    step(0, 1, 1, DMC_SER_NORMAL, 8'h00);
    repeat (3) step(0, 0, 0, 8'h00, 8'h00);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    mreset(1);
    step(0, 0, 0, 8'h00, 8'h00);
    rst_n_i = 1'b1;
    repeat (3) step(0, 0, 0, 8'h00, 8'h00);
    final_report();
  end
endmodule : display_mode_command_handler_tb

// ==== bench/dmc_host_model.sv ====
`timescale 1ns/10ps
// Host end of the command link; idle code lines are scrambled.
module dmc_host_model (
  // Command lines towards the controller.
  output logic        cmd_valid_o,
  output logic        cmd_wide_o,
  output logic [15:0] cmd_code_o
);
  // Drives one cycle; an idle cycle inverts the last code.
  task automatic drive(input logic v, input logic w, input logic [7:0] op,
                       input logic [7:0] lo);
    cmd_valid_o = v;
    cmd_wide_o  = w;
    if (!v) cmd_code_o = ~cmd_code_o;
    else if (w) cmd_code_o = {op, lo};
    else cmd_code_o = {8'h00, op};
  endtask : drive
  // Lines start idle.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_wide_o  = 1'b0;
    cmd_code_o  = 16'h0000;
  end
endmodule : dmc_host_model

// ==== core/dmc_decode.sv ====
`timescale 1ns/10ps
// Maps a serial byte or a 16-bit word onto a command kind.
module dmc_decode
  import dmc_pkg::*;
(
  // Command input.
  input  wire logic        wide_i,
  input  wire logic [15:0] code_i,
  // Decoded kind.
  output dmc_cmd_t         cmd_o
);

  logic [7:0] op;
  logic       shape_ok;

  // Serial codes use the low byte; wide codes need a zero low byte.
  assign op       = wide_i ? code_i[15:8] : code_i[7:0];
  assign shape_ok = wide_i ? (code_i[7:0] == DMC_WORD_LOW)
                           : (code_i[15:8] == DMC_WORD_LOW);

  // Opcode table.
  always_comb begin
    cmd_o = DMC_CMD_NONE;
    if (shape_ok) begin
      case (op)
        DMC_SER_SLEEP_ENTRY: cmd_o = DMC_CMD_SLEEP_ENTRY;
        DMC_SER_SLEEP_EXIT:  cmd_o = DMC_CMD_SLEEP_EXIT;
        DMC_SER_PARTIAL:     cmd_o = DMC_CMD_PARTIAL;
        DMC_SER_NORMAL:      cmd_o = DMC_CMD_NORMAL;
        DMC_SER_INV_CLEAR:   cmd_o = DMC_CMD_INV_CLEAR;
        DMC_SER_INV_SET:     cmd_o = DMC_CMD_INV_SET;
        default:             cmd_o = DMC_CMD_NONE;
      endcase
    end
  end

endmodule : dmc_decode

// ==== core/dmc_mode_ctrl.sv ====
`timescale 1ns/10ps
module dmc_mode_ctrl
  import dmc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Software reset command, one-cycle pulse.
  input  wire logic        soft_rst_i,
  // Command strobe and code.
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_wide_i,
  input  wire logic [15:0] cmd_code_i,
  // Mode state.
  output logic             asleep_o,
  output logic             partial_o,
  output logic             inverted_o,
  // Frame-boundary update strobe and host timing status.
  output logic             mode_update_o,
  output logic             host_wait_o,
  output logic             timing_err_o
);

  dmc_cmd_t               cmd;
  logic                   take;
  logic                   asleep_q;
  logic                   partial_q;
  logic                   inverted_q;
  logic                   upd_q;
  logic [DMC_CNT_W-1:0]   in_cnt_q;
  logic [DMC_CNT_W-1:0]   out_cnt_q;
  logic                   err_q;

  // Command decoder.
  dmc_decode u_decode (
    .wide_i (cmd_wide_i),
    .code_i (cmd_code_i),
    .cmd_o  (cmd)
  );

  assign take = cmd_valid_i;

  // Sleep state; a command that matches the current state is ignored.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      asleep_q <= DMC_RST_ASLEEP;
    end else if (soft_rst_i) begin
      asleep_q <= DMC_RST_ASLEEP;
    end else if (take && cmd == DMC_CMD_SLEEP_ENTRY) begin
      asleep_q <= 1'b1;
    end else if (take && cmd == DMC_CMD_SLEEP_EXIT) begin
      asleep_q <= 1'b0;
    end
  end

  // Partial/normal state: one flag keeps the two modes exclusive.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      partial_q <= DMC_RST_PARTIAL;
    end else if (soft_rst_i) begin
      partial_q <= DMC_RST_PARTIAL;
    end else if (take && cmd == DMC_CMD_NORMAL) begin
      partial_q <= 1'b0;
    end else if (take && cmd == DMC_CMD_PARTIAL) begin
      partial_q <= 1'b1;
    end
  end

  // Inversion flag; frame memory is never touched here.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inverted_q <= DMC_RST_INVERTED;
    end else if (soft_rst_i) begin
      inverted_q <= DMC_RST_INVERTED;
    end else if (take && cmd == DMC_CMD_INV_SET) begin
      inverted_q <= 1'b1;
    end else if (take && cmd == DMC_CMD_INV_CLEAR) begin
      inverted_q <= 1'b0;
    end
  end

  // Pulse when the partial/normal mode really changes, so the scan logic swaps
  // mode at a frame edge instead of mid-line; repeats give no pulse.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= (soft_rst_i && partial_q) ||
               (take && !soft_rst_i &&
                ((cmd == DMC_CMD_NORMAL && partial_q) ||
                 (cmd == DMC_CMD_PARTIAL && !partial_q)));
    end
  end

  // Wait after sleep entry: count down 5 ms.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_cnt_q <= '0;
    end else if (take && !soft_rst_i && !asleep_q &&
                 cmd == DMC_CMD_SLEEP_ENTRY) begin
      in_cnt_q <= DMC_CNT_W'(DMC_SLEEP_IN_CYC);
    end else if (in_cnt_q != '0) begin
      in_cnt_q <= in_cnt_q - 1'b1;
    end
  end

  // Wait after sleep exit: count down 120 ms.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_cnt_q <= '0;
    end else if (take && !soft_rst_i && asleep_q &&
                 cmd == DMC_CMD_SLEEP_EXIT) begin
      out_cnt_q <= DMC_CNT_W'(DMC_SLEEP_OUT_CYC);
    end else if (out_cnt_q != '0) begin
      out_cnt_q <= out_cnt_q - 1'b1;
    end
  end

  // Sticky flag when the host breaks a wait; cleared only by a reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q <= 1'b0;
    end else if (take && ((in_cnt_q != '0) ||
             (out_cnt_q != '0 && cmd == DMC_CMD_SLEEP_ENTRY))) begin
      err_q <= 1'b1;
    end else if (soft_rst_i) begin
      err_q <= 1'b0;
    end
  end

  // Output drive.
  assign asleep_o      = asleep_q;
  assign partial_o     = partial_q;
  assign inverted_o    = inverted_q;
  assign mode_update_o = upd_q;
  assign host_wait_o   = (in_cnt_q != '0);
  assign timing_err_o  = err_q;

  // Checks.
  sequence normal_seen;
    cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_NORMAL;
  endsequence

  sequence partial_seen;
    cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_PARTIAL;
  endsequence

  normal_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    normal_seen |=> !partial_o)
    else $error("normal command left partial set");

  partial_sets_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    partial_seen |=> partial_o)
    else $error("partial command did not set partial");

  partial_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (partial_o && !(cmd_valid_i && cmd == DMC_CMD_NORMAL) && !soft_rst_i)
      |=> partial_o)
    else $error("partial mode left without normal command");

  normal_repeat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (normal_seen and !partial_o) |=> !mode_update_o && !partial_o)
    else $error("repeated normal command had an effect");

  partial_repeat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (partial_seen and partial_o) |=> !mode_update_o && partial_o)
    else $error("repeated partial command had an effect");

  swap_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(partial_o) |-> mode_update_o)
    else $error("mode changed without update pulse");

  soft_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_rst_i |=> asleep_o && !partial_o && !inverted_o)
    else $error("soft reset did not restore defaults");

  asleep_normal_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (normal_seen and asleep_o) |=> !partial_o)
    else $error("normal command refused while asleep");

  sleep_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_SLEEP_EXIT)
      |=> !asleep_o)
    else $error("sleep exit did not wake");

  inv_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_INV_SET)
      |=> inverted_o)
    else $error("inversion set failed");

  wait_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_SLEEP_ENTRY && !asleep_o)
      |=> host_wait_o [*8])
    else $error("sleep entry wait not held");

  inv_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_INV_CLEAR)
      |=> !inverted_o)
    else $error("inversion clear failed");

  sleep_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !soft_rst_i && cmd == DMC_CMD_SLEEP_ENTRY)
      |=> asleep_o)
    else $error("sleep entry did not sleep");

  update_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_update_o |-> $changed(partial_o))
    else $error("update pulse without mode change");

  wait_err_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && host_wait_o) |=> timing_err_o)
    else $error("command during sleep entry wait not flagged");

  early_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_valid_i && cmd == DMC_CMD_SLEEP_ENTRY && out_cnt_q != '0)
      |=> timing_err_o)
    else $error("early sleep entry not flagged");

  err_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timing_err_o && !soft_rst_i) |=> timing_err_o)
    else $error("timing error flag dropped");

endmodule : dmc_mode_ctrl

// ==== include/dmc_pkg.sv ====
package dmc_pkg;

  // Command codes on the one-byte serial display link.
  localparam logic [7:0] DMC_SER_SLEEP_ENTRY = 8'h10;
  localparam logic [7:0] DMC_SER_SLEEP_EXIT  = 8'h11;
  localparam logic [7:0] DMC_SER_PARTIAL     = 8'h12;
  localparam logic [7:0] DMC_SER_NORMAL      = 8'h13;
  localparam logic [7:0] DMC_SER_INV_CLEAR   = 8'h20;
  localparam logic [7:0] DMC_SER_INV_SET     = 8'h21;

  // Low byte of a 16-bit command word; the opcode sits in the high byte.
  localparam logic [7:0] DMC_WORD_LOW = 8'h00;

  // Reset values of the mode state.
  localparam logic DMC_RST_ASLEEP   = 1'b1;
  localparam logic DMC_RST_PARTIAL  = 1'b0;
  localparam logic DMC_RST_INVERTED = 1'b0;

  // Host wait times and their cycle counts at 25 MHz.
  localparam int DMC_CLK_HZ          = 25000000;
  localparam int DMC_SLEEP_IN_MS     = 5;
  localparam int DMC_SLEEP_OUT_MS    = 120;
  localparam int DMC_SLEEP_IN_CYC    = DMC_CLK_HZ / 1000 * DMC_SLEEP_IN_MS;
  localparam int DMC_SLEEP_OUT_CYC   = DMC_CLK_HZ / 1000 * DMC_SLEEP_OUT_MS;
  localparam int DMC_CNT_W           = 22;

  // Decoded command kinds.
  typedef enum logic [2:0] {
    DMC_CMD_NONE        = 3'b000,
    DMC_CMD_SLEEP_ENTRY = 3'b001,
    DMC_CMD_SLEEP_EXIT  = 3'b010,
    DMC_CMD_PARTIAL     = 3'b011,
    DMC_CMD_NORMAL      = 3'b100,
    DMC_CMD_INV_CLEAR   = 3'b101,
    DMC_CMD_INV_SET     = 3'b110
  } dmc_cmd_t;

endpackage : dmc_pkg
